// [src/sfr_pkg.sv]
// shared constants, field layouts and carrier types of the fault reaction block
package sfr_pkg;

    // ==================================================================
    // clock and timing
    localparam int NUM_CH            = 8;
    localparam int SYS_CLK_PERIOD_NS = 50;
    localparam int SAMPLE_PERIOD_NS  = 12200;
    localparam int SAMPLE_CYCLES     =
        (SAMPLE_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_CYCLES - 1);
    localparam int RETRY_DELAY_US    = 1000;
    localparam int RETRY_CYCLES_DEF  =
        RETRY_DELAY_US * 1000 / SYS_CLK_PERIOD_NS;

    // ==================================================================
    // reaction byte fields
    localparam logic [1:0] ACT_CONTINUE = 2'h0;
    localparam logic [1:0] ACT_DEGLITCH = 2'h1;
    localparam logic [2:0] RETRY_LATCH  = 3'h0;
    localparam logic [2:0] DLY_NONE     = 3'h0;
    localparam logic [7:0] REACT_RST    = 8'h80;

    typedef struct packed {
        logic [1:0] action;
        logic [2:0] retry;
        logic [2:0] delay;
    } sfr_reaction_t;

    // ==================================================================
    // command codes on the internal command port
    localparam logic [7:0] CMD_CLEAR_FLAGS   = 8'h03;
    localparam logic [7:0] CMD_OUT_OV_REACT  = 8'h10;
    localparam logic [7:0] CMD_OUT_UV_REACT  = 8'h11;
    localparam logic [7:0] CMD_OT_REACT      = 8'h12;
    localparam logic [7:0] CMD_UT_REACT      = 8'h13;
    localparam logic [7:0] CMD_IN_OV_REACT   = 8'h14;
    localparam logic [7:0] CMD_IN_UV_REACT   = 8'h15;
    localparam logic [7:0] CMD_STATUS_BYTE   = 8'h20;
    localparam logic [7:0] CMD_STATUS_WORD_H = 8'h21;
    localparam logic [7:0] CMD_STATUS_VOUT   = 8'h22;
    localparam logic [7:0] CMD_STATUS_INPUT  = 8'h23;
    localparam logic [7:0] CMD_STATUS_TEMP   = 8'h24;
    localparam logic [7:0] RDATA_NONE        = 8'h00;

    // ==================================================================
    // status bit positions
    localparam int SB_OFF       = 6;
    localparam int SB_VOUT_OV   = 5;
    localparam int SB_VIN_UV    = 3;
    localparam int SB_TEMP      = 2;
    localparam int SB_HIGH_BYTE = 0;
    localparam int SWH_VOUT     = 7;
    localparam int SWH_INPUT    = 5;
    localparam int SD_OVER      = 7;
    localparam int SD_UNDER     = 4;

    // ==================================================================
    // carriers
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [2:0] page;
        logic [7:0] code;
        logic [7:0] data;
    } sfr_cmd_t;

    typedef struct packed {
        logic over_temp;
        logic under_temp;
        logic in_over;
        logic in_under;
    } sfr_adc_fault_t;

    typedef enum logic [2:0] {
        CH_RUN     = 3'b001,
        CH_LATCHED = 3'b010,
        CH_RETRY   = 3'b100
    } sfr_ch_state_t;

    typedef struct packed {
        sfr_reaction_t [NUM_CH-1:0] ov_react;
        sfr_reaction_t [NUM_CH-1:0] uv_react;
        sfr_reaction_t              ot_react;
        sfr_reaction_t              ut_react;
        sfr_reaction_t              in_ov_react;
        sfr_reaction_t              in_uv_react;
        logic [NUM_CH-1:0]          ctl_meta;
        logic [NUM_CH-1:0]          ctl_sync;
        logic                       bias_meta;
        logic                       bias_sync;
        logic [NUM_CH-1:0]          vout_ov_flag;
        logic [NUM_CH-1:0]          vout_uv_flag;
        logic                       in_ov_flag;
        logic                       in_uv_flag;
        logic                       ot_flag;
        logic                       ut_flag;
        logic [7:0]                 sample_div;
        logic                       sample_tick;
        logic [7:0]                 rdata;
        logic                       rvalid;
        logic                       alert;
    } sfr_top_state_t;

endpackage

// [src/sfr_channel.sv]
// per-channel deglitch, shutdown and retry sequencer
`timescale 1ns/1ps
`default_nettype none

module sfr_channel
    import sfr_pkg::*;
#(
    parameter int RETRY_W      = 16,
    parameter int RETRY_CYCLES = 1000
) (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_sync_n,
    // timing and control
    input  wire logic          sample_tick,
    input  wire logic          run_request,
    // faults and their reactions
    input  wire logic          ov_fault,
    input  wire logic          uv_fault,
    input  wire sfr_reaction_t ov_cfg,
    input  wire sfr_reaction_t uv_cfg,
    input  wire logic          adc_trip,
    input  wire logic [2:0]    adc_retry,
    // outputs
    output logic               channel_enable,
    output logic               channel_off
);

    typedef struct packed {
        sfr_ch_state_t      st;
        logic [2:0]         ov_cnt;
        logic [2:0]         uv_cnt;
        logic [RETRY_W-1:0] wait_cnt;
        logic               en;
    } sfr_ch_reg_t;

    localparam logic [RETRY_W-1:0] WAIT_LAST = RETRY_W'(RETRY_CYCLES - 1);

    sfr_ch_reg_t state_reg;
    sfr_ch_reg_t state_next;

    always_comb begin
        logic       ov_soft;
        logic       uv_soft;
        logic       ov_trip;
        logic       uv_trip;
        logic       trip;
        logic [2:0] trip_retry;
        ov_soft    = 1'b0;
        uv_soft    = 1'b0;
        ov_trip    = 1'b0;
        uv_trip    = 1'b0;
        trip       = 1'b0;
        trip_retry = RETRY_LATCH;
        state_next = state_reg;

        // deglitch runs only while the output is on
        if (state_reg.st == CH_RUN && run_request) begin
            ov_soft = ov_fault && ov_cfg.action == ACT_DEGLITCH;
            uv_soft = uv_fault && uv_cfg.action == ACT_DEGLITCH;
            ov_trip = (ov_fault && ov_cfg.action[1]) ||
                      (ov_soft && state_reg.ov_cnt == ov_cfg.delay);
            uv_trip = (uv_fault && uv_cfg.action[1]) ||
                      (uv_soft && state_reg.uv_cnt == uv_cfg.delay);
        end
        // count whole samples; a vanished fault starts over
        if (!ov_soft) begin
            state_next.ov_cnt = 3'h0;
        end else if (sample_tick && state_reg.ov_cnt != ov_cfg.delay) begin
            state_next.ov_cnt = state_reg.ov_cnt + 3'h1;
        end
        if (!uv_soft) begin
            state_next.uv_cnt = 3'h0;
        end else if (sample_tick && state_reg.uv_cnt != uv_cfg.delay) begin
            state_next.uv_cnt = state_reg.uv_cnt + 3'h1;
        end

        // action 00 never reaches a trip term
        if (ov_trip) begin
            trip       = 1'b1;
            trip_retry = ov_cfg.retry;
        end else if (uv_trip) begin
            trip       = 1'b1;
            trip_retry = uv_cfg.retry;
        end else if (adc_trip && run_request) begin
            trip       = 1'b1;
            trip_retry = adc_retry;
        end

        unique case (state_reg.st)
            CH_RUN: begin
                if (trip) begin
                    state_next.st = (trip_retry == RETRY_LATCH) ?
                                    CH_LATCHED : CH_RETRY;
                    state_next.wait_cnt = '0;
                end
            end
            CH_LATCHED: begin
                // only a drop of the run request releases the latch
                if (!run_request) begin
                    state_next.st = CH_RUN;
                end
            end
            CH_RETRY: begin
                if (!run_request) begin
                    state_next.st = CH_RUN;
                end else if (adc_trip) begin
                    state_next.st = (adc_retry == RETRY_LATCH) ?
                                    CH_LATCHED : CH_RETRY;
                    state_next.wait_cnt = '0;
                end else if (state_reg.wait_cnt == WAIT_LAST) begin
                    state_next.st = CH_RUN;
                end else begin
                    state_next.wait_cnt = state_reg.wait_cnt + 1'b1;
                end
            end
        endcase

        state_next.en = run_request && state_next.st == CH_RUN;
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg <= '{st: CH_RUN, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign channel_enable = state_reg.en;
    assign channel_off    = !state_reg.en;

endmodule

`default_nettype wire

// [src/sfr_fault_manager.sv]
// top of the supply fault reaction block: registers, flags, alert, channels
//
// Summary of operation
// - action 00 keeps the channel running when a fault is seen
// - output fault action 01 runs for the delay, then shuts down and follows retry field
// - output fault action 1x shuts down at once, then follows retry field
// - retry 000 latches the channel off until control pin, on/off command or bias drops
// - nonzero retry restarts forever after the interval, until off or new fault
// - output fault delay 000 turns the channel off immediately
// - nonzero delay ignores a new fault for that many 12.2 us samples
// - output faults set summary flags and the channel output status flag
// - every fault but a masked odd-channel output fault pulls the active-low alert line
// - odd channels in current mode ignore output over and under faults
// - converter faults are not deglitched and set summary and detail flags
// - converter fault action other than 00 shuts down, then retry field
// - converter delay field reads 000 and ignores writes
// - latch clears by control pin, on/off command or bias; flag clear does not
`timescale 1ns/1ps
`default_nettype none

module sfr_fault_manager
    import sfr_pkg::*;
#(
    parameter int RETRY_CYCLES = RETRY_CYCLES_DEF
) (
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    // command port from the serial command decoder
    input  wire sfr_cmd_t            cmd,
    output logic [7:0]               cmd_rdata,
    output logic                     cmd_rvalid,
    // channel control
    input  wire logic [NUM_CH-1:0]   control_pin,
    input  wire logic [NUM_CH-1:0]   operation_on,
    input  wire logic                bias_good_pin,
    input  wire logic [NUM_CH-1:0]   hires_current_mode,
    // fault detectors
    input  wire logic [NUM_CH-1:0]   vout_ov_fault,
    input  wire logic [NUM_CH-1:0]   vout_uv_fault,
    input  wire sfr_adc_fault_t      adc_fault,
    // supply enables
    output logic [NUM_CH-1:0]        channel_enable,
    // open-drain alert pin
    output logic                     host_alert_line_n_o,
    output logic                     host_alert_line_n_oe
);

    localparam int RETRY_W = $clog2(RETRY_CYCLES + 1);

    // ==================================================================
    // reset release
    logic [1:0] rst_pipe_reg;
    logic       rst_sync_n;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_reg[1];

    // ==================================================================
    // state
    sfr_top_state_t    state_reg;
    sfr_top_state_t    state_next;
    logic [NUM_CH-1:0] ov_seen;
    logic [NUM_CH-1:0] uv_seen;
    logic [NUM_CH-1:0] run_request;
    logic [NUM_CH-1:0] ch_off;
    logic              adc_trip;
    logic [2:0]        adc_retry;
    logic [7:0]        status_byte;
    logic [7:0]        status_word_hi;

    // current-mode odd channels never see their output faults
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            localparam bit ODD = (gi % 2) == 1;
            logic masked;
            assign masked = ODD && hires_current_mode[gi];
            assign ov_seen[gi] = vout_ov_fault[gi] && !masked;
            assign uv_seen[gi] = vout_uv_fault[gi] && !masked;
            // bias loss or a dropped control ends a latch or a retry
            assign run_request[gi] = state_reg.ctl_sync[gi] &&
                                     operation_on[gi] &&
                                     state_reg.bias_sync;

            sfr_channel #(
                .RETRY_W      (RETRY_W),
                .RETRY_CYCLES (RETRY_CYCLES)
            ) u_channel (
                .sys_clk        (sys_clk),
                .rst_sync_n     (rst_sync_n),
                .sample_tick    (state_reg.sample_tick),
                .run_request    (run_request[gi]),
                .ov_fault       (ov_seen[gi]),
                .uv_fault       (uv_seen[gi]),
                .ov_cfg         (state_reg.ov_react[gi]),
                .uv_cfg         (state_reg.uv_react[gi]),
                .adc_trip       (adc_trip),
                .adc_retry      (adc_retry),
                .channel_enable (channel_enable[gi]),
                .channel_off    (ch_off[gi])
            );
        end
    endgenerate

    // ==================================================================
    // converter faults trip every channel; first one in order names retry
    always_comb begin
        logic ot_hit;
        logic ut_hit;
        logic iov_hit;
        logic iuv_hit;
        ot_hit  = adc_fault.over_temp &&
                  state_reg.ot_react.action != ACT_CONTINUE;
        ut_hit  = adc_fault.under_temp &&
                  state_reg.ut_react.action != ACT_CONTINUE;
        iov_hit = adc_fault.in_over &&
                  state_reg.in_ov_react.action != ACT_CONTINUE;
        iuv_hit = adc_fault.in_under &&
                  state_reg.in_uv_react.action != ACT_CONTINUE;
        adc_trip  = ot_hit || ut_hit || iov_hit || iuv_hit;
        if (ot_hit) begin
            adc_retry = state_reg.ot_react.retry;
        end else if (ut_hit) begin
            adc_retry = state_reg.ut_react.retry;
        end else if (iov_hit) begin
            adc_retry = state_reg.in_ov_react.retry;
        end else begin
            adc_retry = state_reg.in_uv_react.retry;
        end
    end

    // ==================================================================
    // summary status
    always_comb begin
        status_word_hi = 8'h00;
        status_word_hi[SWH_VOUT]  = |state_reg.vout_ov_flag ||
                                    |state_reg.vout_uv_flag;
        status_word_hi[SWH_INPUT] = state_reg.in_ov_flag ||
                                    state_reg.in_uv_flag;
        status_byte = 8'h00;
        status_byte[SB_OFF]       = |ch_off;
        status_byte[SB_VOUT_OV]   = |state_reg.vout_ov_flag;
        status_byte[SB_VIN_UV]    = state_reg.in_uv_flag;
        status_byte[SB_TEMP]      = state_reg.ot_flag ||
                                    state_reg.ut_flag;
        status_byte[SB_HIGH_BYTE] = |status_word_hi;
    end

    // ==================================================================
    // next state
    always_comb begin
        logic       wr;
        logic       rd;
        logic       clr;
        logic [2:0] pg;
        logic [7:0] rd_byte;
        wr  = cmd.valid && cmd.write;
        rd  = cmd.valid && !cmd.write;
        clr = wr && cmd.code == CMD_CLEAR_FLAGS;
        pg  = cmd.page;
        rd_byte = RDATA_NONE;
        state_next = state_reg;

        // pins cross into the clock domain through two flops
        state_next.ctl_meta  = control_pin;
        state_next.ctl_sync  = state_reg.ctl_meta;
        state_next.bias_meta = bias_good_pin;
        state_next.bias_sync = state_reg.bias_meta;

        // supervisor sample enable
        state_next.sample_tick = state_reg.sample_div == SAMPLE_LAST;
        state_next.sample_div  = (state_reg.sample_div == SAMPLE_LAST) ?
                                 8'h00 : state_reg.sample_div + 8'h01;

        // register writes
        if (wr) begin
            unique case (cmd.code)
                CMD_OUT_OV_REACT: state_next.ov_react[pg] = cmd.data;
                CMD_OUT_UV_REACT: state_next.uv_react[pg] = cmd.data;
                CMD_OT_REACT: begin
                    state_next.ot_react       = cmd.data;
                    state_next.ot_react.delay = DLY_NONE;
                end
                CMD_UT_REACT: begin
                    state_next.ut_react       = cmd.data;
                    state_next.ut_react.delay = DLY_NONE;
                end
                CMD_IN_OV_REACT: begin
                    state_next.in_ov_react       = cmd.data;
                    state_next.in_ov_react.delay = DLY_NONE;
                end
                CMD_IN_UV_REACT: begin
                    state_next.in_uv_react       = cmd.data;
                    state_next.in_uv_react.delay = DLY_NONE;
                end
                default: begin
                end
            endcase
        end

        // flag clear only touches flags, never a latched-off channel
        if (clr) begin
            state_next.vout_ov_flag = '0;
            state_next.vout_uv_flag = '0;
            state_next.in_ov_flag   = 1'b0;
            state_next.in_uv_flag   = 1'b0;
            state_next.ot_flag      = 1'b0;
            state_next.ut_flag      = 1'b0;
        end
        // a fault in the clearing cycle still sets its flag
        state_next.vout_ov_flag = state_next.vout_ov_flag | ov_seen;
        state_next.vout_uv_flag = state_next.vout_uv_flag | uv_seen;
        state_next.in_ov_flag   = state_next.in_ov_flag ||
                                  adc_fault.in_over;
        state_next.in_uv_flag   = state_next.in_uv_flag ||
                                  adc_fault.in_under;
        state_next.ot_flag      = state_next.ot_flag ||
                                  adc_fault.over_temp;
        state_next.ut_flag      = state_next.ut_flag ||
                                  adc_fault.under_temp;

        // alert follows any set flag, whatever the action was
        state_next.alert = |state_next.vout_ov_flag ||
                           |state_next.vout_uv_flag ||
                           state_next.in_ov_flag || state_next.in_uv_flag ||
                           state_next.ot_flag || state_next.ut_flag;

        // register reads
        unique case (cmd.code)
            CMD_OUT_OV_REACT:  rd_byte = state_reg.ov_react[pg];
            CMD_OUT_UV_REACT:  rd_byte = state_reg.uv_react[pg];
            CMD_OT_REACT:      rd_byte = state_reg.ot_react;
            CMD_UT_REACT:      rd_byte = state_reg.ut_react;
            CMD_IN_OV_REACT:   rd_byte = state_reg.in_ov_react;
            CMD_IN_UV_REACT:   rd_byte = state_reg.in_uv_react;
            CMD_STATUS_BYTE:   rd_byte = status_byte;
            CMD_STATUS_WORD_H: rd_byte = status_word_hi;
            CMD_STATUS_VOUT: begin
                rd_byte[SD_OVER]  = state_reg.vout_ov_flag[pg];
                rd_byte[SD_UNDER] = state_reg.vout_uv_flag[pg];
            end
            CMD_STATUS_INPUT: begin
                rd_byte[SD_OVER]  = state_reg.in_ov_flag;
                rd_byte[SD_UNDER] = state_reg.in_uv_flag;
            end
            CMD_STATUS_TEMP: begin
                rd_byte[SD_OVER]  = state_reg.ot_flag;
                rd_byte[SD_UNDER] = state_reg.ut_flag;
            end
            default: rd_byte = RDATA_NONE;
        endcase
        state_next.rvalid = rd;
        if (rd) begin
            state_next.rdata = rd_byte;
        end
    end

    // ==================================================================
    // state register
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg             <= '0;
            state_reg.ov_react    <= {NUM_CH{REACT_RST}};
            state_reg.uv_react    <= {NUM_CH{REACT_RST}};
            state_reg.ot_react    <= REACT_RST;
            state_reg.ut_react    <= REACT_RST;
            state_reg.in_ov_react <= REACT_RST;
            state_reg.in_uv_react <= REACT_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==================================================================
    // outputs
    assign cmd_rdata            = state_reg.rdata;
    assign cmd_rvalid           = state_reg.rvalid;
    assign host_alert_line_n_o  = 1'b0;
    assign host_alert_line_n_oe = state_reg.alert;

endmodule

`default_nettype wire

// [test/sfr_supply_model.sv]
// behavioural model of the eight controlled supplies
`timescale 1ns/1ps
`default_nettype none

module sfr_supply_model
    import sfr_pkg::*;
(
    // ==== enables and requested faults
    input  wire logic [NUM_CH-1:0] enable,
    input  wire logic [NUM_CH-1:0] over_req,
    input  wire logic [NUM_CH-1:0] under_req,
    // ==== supervisor fault levels
    output logic [NUM_CH-1:0]      over_flt,
    output logic [NUM_CH-1:0]      under_flt
);
    // a supply that is off has no output, so it cannot show a fault
    assign over_flt  = over_req & enable;
    assign under_flt = under_req & enable;
endmodule

`default_nettype wire

// [test/sfr_fault_manager_props.sv]
// port checker bound to the fault reaction block
`timescale 1ns/1ps
`default_nettype none

module sfr_props
    import sfr_pkg::*;
(
    // ==== watched ports
    input wire logic              sys_clk,
    input wire logic              rst_n,
    input wire sfr_cmd_t          cmd,
    input wire logic [7:0]        cmd_rdata,
    input wire logic              cmd_rvalid,
    input wire logic              bias_good_pin,
    input wire logic [NUM_CH-1:0] vout_ov_fault,
    input wire logic [NUM_CH-1:0] vout_uv_fault,
    input wire sfr_adc_fault_t    adc_fault,
    input wire logic [NUM_CH-1:0] channel_enable,
    input wire logic              host_alert_line_n_o,
    input wire logic              host_alert_line_n_oe
);
    logic [1:0]    up_reg;
    sfr_reaction_t ov0_reg;
    logic          rd, wr, up, quiet;
    assign up    = up_reg == 2'h3;
    assign rd    = cmd.valid && !cmd.write;
    assign wr    = cmd.valid && cmd.write && up;
    assign quiet = !(|{vout_ov_fault, vout_uv_fault, adc_fault});
    // channel 0 over reaction mirror predicts its shutdown
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_reg  <= 2'h0;
            ov0_reg <= REACT_RST;
        end else begin
            up_reg <= up ? up_reg : up_reg + 2'h1;
            if (wr && cmd.code == CMD_OUT_OV_REACT && cmd.page == 3'h0)
                ov0_reg <= cmd.data;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_pin_low: assert property (host_alert_line_n_o == 1'b0)
        else $error("alert pin output not low");
    a_out_alert:
        assert property (up && |(vout_ov_fault & 8'h55) |=> host_alert_line_n_oe)
        else $error("output fault gave no alert");
    a_conv_alert: assert property (up && |adc_fault |=> host_alert_line_n_oe)
        else $error("converter fault gave no alert");
    a_clear_alert:
        assert property (wr && cmd.code == CMD_CLEAR_FLAGS && quiet
            |=> !host_alert_line_n_oe) else $error("alert kept after clear");
    a_ov_shut:
        assert property (up && vout_ov_fault[0] && channel_enable[0]
            && ov0_reg.action != ACT_CONTINUE
            && (ov0_reg.action[1] || ov0_reg.delay == DLY_NONE)
            |=> !channel_enable[0]) else $error("channel 0 not shut");
    a_bias_off:
        assert property (!bias_good_pin [*4] |-> channel_enable == '0)
        else $error("channel on without bias");
    a_read_ack: assert property (rd |=> cmd_rvalid)
        else $error("read not answered");
    a_conv_delay:
        assert property (rd && cmd.code inside {[CMD_OT_REACT:CMD_IN_UV_REACT]}
            |=> cmd_rdata[2:0] == DLY_NONE) else $error("delay bits not zero");
endmodule

bind sfr_fault_manager sfr_props u_props (.sys_clk, .rst_n, .cmd, .cmd_rdata,
    .cmd_rvalid, .bias_good_pin, .vout_ov_fault, .vout_uv_fault, .adc_fault,
    .channel_enable, .host_alert_line_n_o, .host_alert_line_n_oe);

`default_nettype wire

// [test/tb_supply_fault_response_manager.sv]
// self-checking bench of the supply fault reaction block
`timescale 1ns/1ps
`default_nettype none

module tb_supply_fault_response_manager
    import sfr_pkg::*;
;
    typedef struct packed {logic w; logic [7:0] c, d, e;} sfr_row_t;
    logic           sys_clk, rst_n, bias, cmd_rvalid, oe, pin_o;
    logic [7:0]     cmd_rdata, ctl, op, hires, ovr, uvr, ov, uv, en;
    sfr_cmd_t       cmd;
    sfr_adc_fault_t adc;
    int             bad_count, n_compared;
    sfr_row_t       rows [8] = '{25'h010_0080, 25'h015_0080, 25'h113_fff8,
        25'h114_4740, 25'h111_5a5a, 25'h07f_0000, 25'h17e_5500, 25'h111_8080};
    sfr_fault_manager #(.RETRY_CYCLES(8)) DUT (.sys_clk, .rst_n, .cmd,
        .cmd_rdata, .cmd_rvalid, .control_pin(ctl), .operation_on(op),
        .bias_good_pin(bias), .hires_current_mode(hires), .vout_ov_fault(ov),
        .vout_uv_fault(uv), .adc_fault(adc), .channel_enable(en),
        .host_alert_line_n_o(pin_o), .host_alert_line_n_oe(oe));
    sfr_supply_model u_sup (.enable(en), .over_req(ovr), .under_req(uvr),
        .over_flt(ov), .under_flt(uv));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // ==== bench tasks
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // an idle cycle first keeps valid from being set and cleared in one step
    task automatic send(logic w, logic [7:0] c, logic [2:0] p, logic [7:0] d);
        tick(1);
        cmd = '{1'b1, w, p, c, d};
        tick(1);
        cmd.valid = 1'b0;
    endtask
    task automatic rd(input logic [7:0] c, logic [2:0] p, logic [7:0] e);
        send(1'b0, c, p, 8'h00);
        chk({7'h0, cmd_rvalid}, 8'h01);
        chk(cmd_rdata, e);
    endtask
    task automatic wait_en(input int b, logic [7:0] m, logic [7:0] v);
        for (int k = 0; k < b && (en & m) !== v; k++)
            tick(1);
        chk(en & m, v);
        if ((en & m) !== v)
            final_report();
    endtask
    task automatic clear_flags();
        send(1'b1, CMD_CLEAR_FLAGS, 3'h0, 8'h00);
    endtask
    // ==== main sequence
    initial begin
        {rst_n, bias, ctl, op, hires, ovr, uvr, adc, cmd} = '0;
        {bad_count, n_compared} = '0;
        tick(16);
        chk(en, 8'h00);
        chk({7'h0, oe}, 8'h00);
        rst_n = 1'b1;
        tick(4);
        foreach (rows[k]) begin
            if (rows[k].w)
                send(1'b1, rows[k].c, 3'h0, rows[k].d);
            rd(rows[k].c, 3'h0, rows[k].e);
        end
        $display("register tests done");
        {bias, ctl, op} = {1'b1, 8'hff, 8'hff};
        wait_en(10, 8'hff, 8'hff);
        ovr = 8'h01;
        tick(1);
        chk(en, 8'hfe);
        ovr = 8'h00;
        chk({7'h0, oe}, 8'h01);
        rd(CMD_STATUS_VOUT, 3'h0, 8'h80);
        rd(CMD_STATUS_BYTE, 3'h0, 8'h61);
        rd(CMD_STATUS_WORD_H, 3'h0, 8'h80);
        tick(20);
        chk(en, 8'hfe);
        clear_flags();
        chk({7'h0, oe}, 8'h00);
        chk(en, 8'hfe);
        ctl = 8'hfe;
        tick(4);
        ctl = 8'hff;
        wait_en(10, 8'h01, 8'h01);
        send(1'b1, CMD_OUT_UV_REACT, 3'h1, 8'h00);
        uvr = 8'h02;
        tick(10);
        chk(en, 8'hff);
        uvr = 8'h00;
        clear_flags();
        send(1'b1, CMD_OUT_OV_REACT, 3'h2, 8'h4a);
        ovr = 8'h04;
        tick(200);
        chk(en, 8'hff);
        ovr = 8'h00;
        tick(1);
        ovr = 8'h04;
        tick(200);
        chk(en, 8'hff);
        wait_en(600, 8'h04, 8'h00);
        ovr = 8'h00;
        tick(5);
        chk(en & 8'h04, 8'h00);
        wait_en(20, 8'h04, 8'h04);
        clear_flags();
        {hires, ovr} = {8'h08, 8'h08};
        tick(5);
        chk(en, 8'hff);
        chk({7'h0, oe}, 8'h00);
        rd(CMD_STATUS_VOUT, 3'h3, 8'h00);
        {hires, ovr} = '0;
        $display("output fault tests done");
        adc = 4'b1001;
        tick(1);
        adc = '0;
        chk(en, 8'h00);
        rd(CMD_STATUS_TEMP, 3'h0, 8'h80);
        rd(CMD_STATUS_INPUT, 3'h0, 8'h10);
        rd(CMD_STATUS_BYTE, 3'h0, 8'h4d);
        tick(10);
        chk(en, 8'h00);
        bias = 1'b0;
        tick(4);
        bias = 1'b1;
        wait_en(10, 8'hff, 8'hff);
        $display("converter test done");
        final_report();
    end
endmodule

`default_nettype wire
